// file: design/rxlcs_top.sv
// Receive line configuration and status block for fourteen channels.
`timescale 1ns/1ps
// Functional notes
// - Clock reference gating is active after reset; disable bit reads 0.
// - Gating in T1 stops all E1 references and the 8kHz reference.
// - Gating in E1 stops T1 references, 8kHz keeps running.
// - Writing 1 to the disable bit keeps every reference running.
// - Two-bit code picks 100, 110, 75 or 120 ohm termination.
// - Per channel termination enable; resets to 0, input high impedance.
// - Pin priority 1 lets the termination pin drive all channels.
// - Pin priority 0 ignores the pin; channel bits rule.
// - Resistor code resets to none; 240, 210 or 150 ohm otherwise.
// - Equalizer gain rises with peak feedback up to its limit; a lowered limit pulls it down one cycle later.
// - Each channel reports a read-only six-bit loss in 1dB steps.
// - Threshold at or below loss raises interrupt when enabled.
// - Two-bit code picks slicer level 50, 45, 55 or 68 percent.
// - Without line signal the recovered clock runs from the master.
// - Data changes on rising clock edge, or falling when selected.
// - Fourteen independent channels, each with clock and two data outputs.
// - Each channel runs T1 or E1 from its own control bits.
// - No interrupt unless the global enable is high.
// - Reading status clears it; interrupt output then goes inactive.
module rxlcs_top (
  input  wire logic                               mclk,
  input  wire logic                               rstn,
  input  wire logic [7:0]                         addr,
  input  wire logic [7:0]                         wdata,
  input  wire logic                               wr,
  input  wire logic                               rd,
  output logic      [7:0]                         rdata,
  input  wire rxlcs_pkg::rxlcs_link_s [rxlcs_pkg::NCH-1:0] link_in,
  input  wire logic                               term_pin,
  input  wire logic [rxlcs_pkg::NCH-1:0][5:0]     loss_meas,
  output rxlcs_pkg::rxlcs_rxout_s [rxlcs_pkg::NCH-1:0]     rx_out,
  output logic                                    t1_ref_en,
  output logic                                    e1_ref_en,
  output logic                                    ref8k_en,
  output rxlcs_pkg::rxlcs_term_e                  term_imp_sel,
  output rxlcs_pkg::rxlcs_slice_e                 slicer_sel,
  output logic      [rxlcs_pkg::NCH-1:0]          rx_term_on,
  output logic      [rxlcs_pkg::NCH-1:0][1:0]     ext_res_sel,
  output logic      [rxlcs_pkg::NCH-1:0][2:0]     eq_gain,
  output logic                                    int_o,
  output logic                                    int_oe
);
  import rxlcs_pkg::*;

  localparam int SW = $bits(link_in) + 1 + $bits(loss_meas);

  rxlcs_gctrl_s            gctrl;
  logic [1:0]              gterm;
  logic [5:0]              thr;
  rxlcs_chcfg_s [NCH-1:0]  chcfg;
  logic [NCH-1:0]          istat;
  logic [NCH-1:0]          hit;
  logic [NCH-1:0]          hit_q;
  logic [NCH-1:0]          clr;
  rxlcs_link_s [NCH-1:0]   link_s;
  logic                    pin_s;
  logic [NCH-1:0][5:0]     loss_s;

  // ==========================================================
  // Address decode shared by writes and reads of channel tables.
  function automatic logic ch_hit(input logic [7:0] a,
                                  input logic [7:0] base);
    ch_hit = (a >= base) && (a < base + 8'(NCH));
  endfunction : ch_hit

  function automatic logic [3:0] ch_idx(input logic [7:0] a,
                                        input logic [7:0] base);
    logic [7:0] d;
    d      = a - base;
    ch_idx = d[3:0];
  endfunction : ch_idx

  // ==========================================================
  // Every pin level crosses into the master clock domain here.
  // The loss value changes slowly, so a torn sample lasts one cycle.
  rxlcs_sync #(.W(SW)) u_sync (
    .mclk (mclk),
    .rstn (rstn),
    .d    ({link_in, term_pin, loss_meas}),
    .q    ({link_s, pin_s, loss_s})
  );

  // ==========================================================
  // Register writes; reset values leave gating on, termination off.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      gctrl <= GCTRL_RST;
      gterm <= GTERM_RST;
      thr   <= THR_RST;
      chcfg <= {NCH{CHCFG_RST}};
    end
    else if (wr)
    begin
      if (addr == A_GCTRL)
      begin
        gctrl <= rxlcs_gctrl_s'(wdata[6:0]);
      end
      if (addr == A_GTERM)
      begin
        gterm <= wdata[1:0];
      end
      if (addr == A_THR)
      begin
        thr <= wdata[5:0];
      end
      if (ch_hit(addr, A_CHCFG))
      begin
        chcfg[ch_idx(addr, A_CHCFG)] <= rxlcs_chcfg_s'(wdata);
      end
    end
  end

  // ==========================================================
  // Read data one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata <= 8'h00;
    end
    else if (!rd)
    begin
      rdata <= 8'h00;
    end
    else if (addr == A_GCTRL)
    begin
      rdata <= {1'b0, gctrl};
    end
    else if (addr == A_GTERM)
    begin
      rdata <= {6'h00, gterm};
    end
    else if (addr == A_THR)
    begin
      rdata <= {2'h0, thr};
    end
    else if (addr == A_ISTAT_LO)
    begin
      rdata <= istat[7:0];
    end
    else if (addr == A_ISTAT_HI)
    begin
      rdata <= {2'h0, istat[NCH-1:8]};
    end
    else if (ch_hit(addr, A_CHCFG))
    begin
      rdata <= chcfg[ch_idx(addr, A_CHCFG)];
    end
    else if (ch_hit(addr, A_CHLOSS))
    begin
      rdata <= {2'h0, loss_s[ch_idx(addr, A_CHLOSS)]};
    end
    else
    begin
      rdata <= 8'h00;
    end
  end

  // ==========================================================
  // Fourteen independent channels.
  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    rxlcs_chan u_chan (
      .mclk     (mclk),
      .rstn     (rstn),
      .lnk      (link_s[i]),
      .edge_sel (gctrl.edge_sel),
      .cfg      (chcfg[i]),
      .thr      (thr),
      .level    (loss_s[i]),
      .rxo      (rx_out[i]),
      .eq_gain  (eq_gain[i]),
      .thr_hit  (hit[i])
    );
  end

  // ==========================================================
  // Sticky loss flags. Only a new crossing sets a flag, otherwise a
  // read could never clear a channel that stays above threshold.
  always_comb
  begin
    clr = '0;
    if (rd && addr == A_ISTAT_LO)
    begin
      clr[7:0] = 8'hff;
    end
    if (rd && addr == A_ISTAT_HI)
    begin
      clr[NCH-1:8] = '1;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      hit_q <= '0;
      istat <= '0;
    end
    else
    begin
      hit_q <= hit;
      for (int i = 0; i < NCH; i++)
      begin
        // A new crossing in the clearing cycle still sets the flag.
        istat[i] <= (hit[i] & ~hit_q[i] & chcfg[i].flag_en)
                    | (istat[i] & ~clr[i]);
      end
    end
  end

  // ==========================================================
  // Open-drain interrupt: pulled low while enabled flags remain.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      int_o  <= 1'b0;
      int_oe <= 1'b0;
    end
    else
    begin
      int_o  <= 1'b0;
      int_oe <= gctrl.global_interrupt_enable & (|istat);
    end
  end

  // ==========================================================
  // Reference gating, removing the unused rate to cut noise.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      t1_ref_en <= 1'b1;
      e1_ref_en <= 1'b0;
      ref8k_en  <= 1'b0;
    end
    else
    begin
      t1_ref_en <= gctrl.gate_dis | ~gctrl.e1_mode;
      e1_ref_en <= gctrl.gate_dis | gctrl.e1_mode;
      ref8k_en  <= gctrl.gate_dis | gctrl.e1_mode;
    end
  end

  // ==========================================================
  // Static analog selections; only writes or the pin move them.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      term_imp_sel <= TERM_100;
      slicer_sel   <= SLICE_50;
      rx_term_on   <= '0;
      ext_res_sel  <= '0;
    end
    else
    begin
      term_imp_sel <= rxlcs_term_e'(gterm);
      slicer_sel   <= rxlcs_slice_e'(gctrl.slicer);
      for (int i = 0; i < NCH; i++)
      begin
        rx_term_on[i]  <= gctrl.pin_prio ? pin_s
                                         : chcfg[i].term_en;
        ext_res_sel[i] <= chcfg[i].ext_res;
      end
    end
  end

  // ==========================================================
  // Assertions on gating, termination, selections and status flags.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_status_read;
    rd && (addr == A_ISTAT_LO) ##1 1'b1;
  endsequence

  a_gate_t1: assert property (!gctrl.gate_dis && !gctrl.e1_mode |=>
    !e1_ref_en && !ref8k_en && t1_ref_en) else $error("T1 gating wrong");
  a_gate_e1: assert property (!gctrl.gate_dis && gctrl.e1_mode |=>
    !t1_ref_en && ref8k_en && e1_ref_en) else $error("E1 gating wrong");
  a_gate_off: assert property (gctrl.gate_dis |=>
    t1_ref_en && e1_ref_en && ref8k_en) else $error("references stopped");
  a_term_pin: assert property (gctrl.pin_prio |=>
    rx_term_on == {NCH{$past(pin_s)}}) else $error("pin not in control");
  a_term_reg: assert property (!gctrl.pin_prio |=>
    rx_term_on[0] == $past(chcfg[0].term_en)) else $error("pin not ignored");
  a_int_gated: assert property (!gctrl.global_interrupt_enable |=> !int_oe)
    else $error("interrupt without enable");
  a_stat_clear: assert property (s_status_read |->
    (istat[7:0] & ~($past(hit[7:0]) & ~$past(hit_q[7:0]))) == 8'h00)
    else $error("status not cleared by read");
  a_sel_follow: assert property ($changed(gterm) |=>
    term_imp_sel == $past(gterm)) else $error("termination code lost");

endmodule : rxlcs_top

// file: design/rxlcs_pkg.sv
// Package with constants and types for the receive line config and status.
package rxlcs_pkg;

  // ==========================================================
  // Sizes and register map
  localparam int         NCH        = 14;
  localparam logic [7:0] A_GCTRL    = 8'h00;
  localparam logic [7:0] A_GTERM    = 8'h01;
  localparam logic [7:0] A_THR      = 8'h02;
  localparam logic [7:0] A_ISTAT_LO = 8'h03;
  localparam logic [7:0] A_ISTAT_HI = 8'h04;
  localparam logic [7:0] A_CHCFG    = 8'h10;
  localparam logic [7:0] A_CHLOSS   = 8'h20;

  // ==========================================================
  // Field layouts and codes
  typedef struct packed {
    logic       e1_mode;   // Rate used by the clock reference gating.
    logic [1:0] slicer;    // slicer_threshold_select.
    logic       global_interrupt_enable;       // global_interrupt_enable.
    logic       edge_sel;  // rx_clock_edge_select.
    logic       pin_prio;  // rx_termination_pin_priority.
    logic       gate_dis;  // single_rate_clock_gate_disable.
  } rxlcs_gctrl_s;

  typedef struct packed {
    logic [2:0] eq_max;    // Highest equalizer gain step allowed.
    logic       e1;        // Channel runs at the E1 rate.
    logic       flag_en;   // Cable loss flag may raise the interrupt.
    logic [1:0] ext_res;   // external_resistor_select.
    logic       term_en;   // rx_termination_enable.
  } rxlcs_chcfg_s;

  typedef struct packed {
    logic clk;
    logic pos;
    logic neg;
    logic present;
    logic peak_low;
    logic peak_high;
  } rxlcs_link_s;

  typedef struct packed {
    logic clk;
    logic pos;
    logic neg;
  } rxlcs_rxout_s;

  typedef enum logic [1:0] {
    TERM_100 = 2'h0, TERM_110 = 2'h1, TERM_75 = 2'h2, TERM_120 = 2'h3
  } rxlcs_term_e;

  typedef enum logic [1:0] {
    SLICE_50 = 2'h0, SLICE_45 = 2'h1, SLICE_55 = 2'h2, SLICE_68 = 2'h3
  } rxlcs_slice_e;

  // ==========================================================
  // Reset values
  localparam rxlcs_gctrl_s GCTRL_RST = '0;
  localparam rxlcs_chcfg_s CHCFG_RST = '0;
  localparam logic [1:0]   GTERM_RST = 2'h0;
  localparam logic [5:0]   THR_RST   = 6'h3f;

  // ==========================================================
  // Fallback clock timing, half periods in master clock cycles
  localparam longint CLK_HZ  = 100000000;
  localparam longint T1_HZ   = 1544000;
  localparam longint E1_HZ   = 2048000;
  localparam logic [5:0] T1_HALF = 6'(CLK_HZ / (2 * T1_HZ));
  localparam logic [5:0] E1_HALF = 6'(CLK_HZ / (2 * E1_HZ));

endpackage : rxlcs_pkg

// file: design/rxlcs_sync.sv
// Two flip-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ps
module rxlcs_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // ==========================================================
  // Only the second stage is visible to the rest of the block.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : rxlcs_sync

// file: design/rxlcs_chan.sv
// One receive channel: clock selection, data edge, gain and loss compare.
`timescale 1ns/1ps
module rxlcs_chan (
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  input  wire rxlcs_pkg::rxlcs_link_s  lnk,
  input  wire logic                   edge_sel,
  input  wire rxlcs_pkg::rxlcs_chcfg_s cfg,
  input  wire logic [5:0]             thr,
  input  wire logic [5:0]             level,
  output rxlcs_pkg::rxlcs_rxout_s      rxo,
  output logic [2:0]                  eq_gain,
  output logic                        thr_hit
);
  import rxlcs_pkg::*;

  logic       lclk_q;
  logic       cap_pos;
  logic       cap_neg;
  logic [5:0] fb_cnt;
  logic       fb_clk;
  logic       src_clk;
  logic       lrise;
  logic       upd;
  logic [5:0] half;

  assign lrise = lnk.clk & ~lclk_q;

  // ==========================================================
  // Capture line data on the recovered clock's rising edge.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      lclk_q  <= 1'b0;
      cap_pos <= 1'b0;
      cap_neg <= 1'b0;
    end
    else
    begin
      lclk_q <= lnk.clk;
      if (lrise)
      begin
        cap_pos <= lnk.pos;
        cap_neg <= lnk.neg;
      end
    end
  end

  // ==========================================================
  // Free running reference at the channel's own rate.
  assign half = cfg.e1 ? E1_HALF : T1_HALF;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      fb_cnt <= 6'h00;
      fb_clk <= 1'b0;
    end
    else if (fb_cnt >= half - 6'h01)
    begin
      fb_cnt <= 6'h00;
      fb_clk <= ~fb_clk;
    end
    else
    begin
      fb_cnt <= fb_cnt + 6'h01;
    end
  end

  // ==========================================================
  // Without a line signal the output clock keeps running locally.
  assign src_clk = lnk.present ? lnk.clk : fb_clk;
  assign upd     = (src_clk != rxo.clk) && (src_clk == ~edge_sel);
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rxo <= '0;
    end
    else
    begin
      rxo.clk <= src_clk;
      if (upd)
      begin
        rxo.pos <= lnk.present & cap_pos;
        rxo.neg <= lnk.present & cap_neg;
      end
    end
  end

  // ==========================================================
  // Gain follows the peak detector, one step per line bit, capped.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      eq_gain <= 3'h0;
    end
    else if (eq_gain > cfg.eq_max)
    begin
      eq_gain <= cfg.eq_max;
    end
    else if (lrise && lnk.peak_low && eq_gain < cfg.eq_max)
    begin
      eq_gain <= eq_gain + 3'h1;
    end
    else if (lrise && lnk.peak_high && eq_gain != 3'h0)
    begin
      eq_gain <= eq_gain - 3'h1;
    end
  end

  // ==========================================================
  // Threshold compare; the top turns its rise into a flag.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      thr_hit <= 1'b0;
    end
    else
    begin
      thr_hit <= (thr <= level);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_gain_capped: assert property ($stable(cfg.eq_max) |->
    eq_gain <= cfg.eq_max) else $error("gain above its limit");
  a_data_edge: assert property ($changed(rxo.pos) |->
    $changed(rxo.clk) && rxo.clk == !$past(edge_sel))
    else $error("data changed off the chosen edge");
  a_fallback_clk: assert property (!lnk.present |=>
    rxo.clk == $past(fb_clk)) else $error("clock not from reference");
  a_thr_flag: assert property ((thr <= level) |=> thr_hit)
    else $error("threshold hit missed");

endmodule : rxlcs_chan

// file: tb/rxlcs_framer.sv
// Downstream framer model that samples one channel's recovered clock and data.
`timescale 1ns/1ps
module rxlcs_framer (
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  input  wire rxlcs_pkg::rxlcs_rxout_s rxo,
  input  wire logic                  edge_sel
);
  import rxlcs_pkg::*;
  logic       clk_q;
  logic [1:0] cap[$];
  int         n_edges;

  // ======================================================
  // Sampling
  // Samples on the falling master edge, so the registered outputs have
  // settled; captures on the edge opposite the data update edge.
  always @(negedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      clk_q = 1'b0;
      n_edges = 0;
    end
    else
    begin
      if (rxo.clk !== clk_q)
        n_edges++;
      if (edge_sel ? (rxo.clk && !clk_q) : (!rxo.clk && clk_q))
        cap.push_back({rxo.pos, rxo.neg});
      clk_q = rxo.clk;
    end
  end
endmodule : rxlcs_framer

// file: tb/rx_line_config_status_bench.sv
// Self-checking bench for the receive line configuration block.
`timescale 1ns/1ps
module rx_line_config_status_bench;
  import rxlcs_pkg::*;
  logic                   mclk = 1'b0;
  logic                   rstn = 1'b0;
  logic [7:0]             addr = 8'h00;
  logic [7:0]             wdata = 8'h00;
  logic                   wr = 1'b0;
  logic                   rd = 1'b0;
  logic                   term_pin = 1'b0;
  logic [NCH-1:0][5:0]    loss_meas = '0;
  logic [NCH-1:0]         pres = '0;
  logic                   pk_lo = 1'b0;
  logic                   pk_hi = 1'b0;
  logic                   lrun = 1'b0;
  logic                   lclk = 1'b0;
  logic [1:0]             lbit = 2'h0;
  rxlcs_link_s [NCH-1:0]  link_in;
  logic [7:0]             rdata;
  rxlcs_rxout_s [NCH-1:0] rx_out;
  logic                   t1_ref_en, e1_ref_en, ref8k_en, int_o, int_oe;
  rxlcs_term_e            term_imp_sel;
  rxlcs_slice_e           slicer_sel;
  logic [NCH-1:0]         rx_term_on;
  logic [NCH-1:0][1:0]    ext_res_sel;
  logic [NCH-1:0][2:0]    eq_gain;
  int                     bad_count = 0;
  int                     n_tests = 0;
  int                     seed = 32'hbff8fc9e;
  int                     m_g = 0;
  int                     m_t = 0;
  int                     m_c[NCH];
  logic [1:0]             sent[$];
  // Open-drain interrupt line with its external pull-up.
  wire                    int_line = int_oe ? int_o : 1'b1;

  // ======================================================
  // Clocks and line side
  always #5 mclk = ~mclk;
  // The link clock stands still between frames of traffic.
  initial
  begin
    #2.7;
    forever
    begin
      #40;
      lclk = lrun ? ~lclk : 1'b0;
    end
  end
  // New line bits after each falling link edge, never both rails at once.
  always @(negedge lclk)
  begin
    lbit = 2'($unsigned($random(seed)) % 3);
    sent.push_back(lbit);
  end
  always @*
    for (int i = 0; i < NCH; i++)
      link_in[i] = '{lclk, lbit[1], lbit[0], pres[i], pk_lo, pk_hi};

  rxlcs_top dut (
    .mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .link_in(link_in), .term_pin(term_pin),
    .loss_meas(loss_meas), .rx_out(rx_out), .t1_ref_en(t1_ref_en),
    .e1_ref_en(e1_ref_en), .ref8k_en(ref8k_en),
    .term_imp_sel(term_imp_sel), .slicer_sel(slicer_sel),
    .rx_term_on(rx_term_on), .ext_res_sel(ext_res_sel),
    .eq_gain(eq_gain), .int_o(int_o), .int_oe(int_oe)
  );
  rxlcs_framer framer (
    .mclk(mclk), .rstn(rstn), .rxo(rx_out[0]), .edge_sel(m_g[2])
  );

  // ======================================================
  // Checking, bus and model tasks
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic give_up();
    bad_count++;
    tally_and_finish();
  endtask : give_up
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle
  // The model mirrors writes to the control, termination and channel registers, keeping only the implemented bits.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    if (a == A_GCTRL) m_g = d & 8'h7f;
    if (a == A_GTERM) m_t = d & 8'h03;
    if (a >= A_CHCFG && a < A_CHCFG + NCH) m_c[a - A_CHCFG] = d;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk
  function automatic logic [NCH-1:0] term_exp(input logic pin);
    for (int i = 0; i < NCH; i++)
      term_exp[i] = m_g[1] ? pin : m_c[i][0];
  endfunction : term_exp
  function automatic logic [2*NCH-1:0] res_exp();
    for (int i = 0; i < NCH; i++)
      res_exp[2*i +: 2] = 2'(m_c[i] >> 1);
  endfunction : res_exp
  // Counts master cycles until the channel's recovered clock reaches v.
  task automatic wait_lvl(input int ch, input logic v, output int n);
    for (n = 0; rx_out[ch].clk !== v; n++)
    begin
      if (n == 300) give_up();
      settle(1);
    end
  endtask : wait_lvl
  task automatic period_is(input int exp);
    int a, b;
    wait_lvl(13, 1'b0, a);
    wait_lvl(13, 1'b1, a);
    wait_lvl(13, 1'b0, a);
    wait_lvl(13, 1'b1, b);
    chk(a + b, exp);
  endtask : period_is
  // One frame on channel 0; the alignment between sent and captured bits
  // depends on the pipeline, so a small window of offsets is accepted.
  task automatic data_run();
    int k, off, ok, hit, e0;
    hit = 0;
    e0 = framer.n_edges;
    sent.delete();
    framer.cap.delete();
    lrun = 1'b1;
    settle(250);
    lrun = 1'b0;
    settle(20);
    for (off = -2; off < 4; off++)
    begin
      ok = (framer.cap.size() > 24 && sent.size() > 22);
      for (k = 3; k < 20; k++)
        if (framer.cap[k + off] !== sent[k]) ok = 0;
      hit |= ok;
    end
    chk(hit, 1);
    // Every link bit gives the framer one rising and one falling edge.
    chk(framer.n_edges - e0 >= 2 * sent.size() - 2, 1);
    chk({rx_out[13].pos, rx_out[13].neg}, 0);
  endtask : data_run

  // ======================================================
  // Main sequence
  initial
  begin
    int v, a;
    for (v = 0; v < NCH; v++) m_c[v] = 0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    #1;
    chk({t1_ref_en, e1_ref_en, ref8k_en}, 3'b100);
    rd_chk(A_GCTRL, 8'h00);
    rd_chk(A_THR, 8'h3f);
    rd_chk(A_CHCFG + 8'h05, 8'h00);
    chk({rx_term_on, ext_res_sel}, 0);
    for (v = 0; v < 4; v++)
    begin
      wr_reg(A_GCTRL, 8'(v[1] * 64 + v[0]));
      settle(2);
      a = {v[0] | ~v[1], {2{v[0] | v[1]}}};
      chk({t1_ref_en, e1_ref_en, ref8k_en}, a);
    end
    for (v = 0; v < 4; v++)
    begin
      wr_reg(A_GTERM, 8'(v));
      wr_reg(A_GCTRL, 8'(v << 4));
      settle(2);
      chk(term_imp_sel, v);
      chk(slicer_sel, v);
      rd_chk(A_GCTRL, 8'(m_g));
      rd_chk(A_GTERM, 8'(m_t));
    end
    for (v = 0; v < NCH; v++)
      wr_reg(A_CHCFG + 8'(v), 8'($random(seed)) & 8'h07);
    rd_chk(A_CHCFG + 8'd7, 8'(m_c[7]));
    @(posedge mclk);
    term_pin <= 1'b1;
    settle(5);
    chk(rx_term_on, term_exp(1'b1));
    chk(ext_res_sel, res_exp());
    wr_reg(A_GCTRL, 8'h02);
    settle(5);
    chk(rx_term_on, term_exp(1'b1));
    term_pin <= 1'b0;
    settle(5);
    chk(rx_term_on, term_exp(1'b0));
    wr_reg(A_GCTRL, 8'h00);
    settle(5);
    chk(rx_term_on, term_exp(1'b0));
    for (v = 0; v < NCH; v++)
      loss_meas[v] <= 6'($random(seed));
    wr_reg(A_CHLOSS, 8'hff);
    settle(6);
    for (v = 0; v < NCH; v++)
      rd_chk(A_CHLOSS + 8'(v), 8'(loss_meas[v]));
    rd_chk(8'h7f, 8'h00);
    // Threshold flag: first with the global enable off, then on.
    loss_meas <= '0;
    wr_reg(A_THR, 8'd10);
    wr_reg(A_CHCFG + 8'd3, 8'h08);
    wr_reg(A_CHCFG + 8'd9, 8'h08);
    rd_chk(A_ISTAT_LO, 8'h00);
    loss_meas[3] <= 6'd12;
    loss_meas[9] <= 6'd9;
    settle(10);
    chk(int_line, 1'b1);
    rd_chk(A_ISTAT_LO, 8'h08);
    rd_chk(A_ISTAT_LO, 8'h00);
    wr_reg(A_GCTRL, 8'h08);
    loss_meas[3] <= 6'd5;
    settle(6);
    loss_meas[3] <= 6'd10;
    for (a = 0; int_line !== 1'b0; a++)
    begin
      if (a == 20) give_up();
      settle(1);
    end
    chk(int_line, 1'b0);
    rd_chk(A_ISTAT_HI, 8'h00);
    rd_chk(A_ISTAT_LO, 8'h08);
    settle(1);
    chk(int_line, 1'b1);
    // Channel 9 crosses next, so the upper status byte is seen set.
    loss_meas[9] <= 6'd20;
    settle(8);
    chk(int_line, 1'b0);
    rd_chk(A_ISTAT_HI, 8'h02);
    rd_chk(A_ISTAT_HI, 8'h00);
    // Channel 13 has no signal and free-runs; channel 0 carries data.
    period_is(2 * int'(T1_HALF));
    wr_reg(A_CHCFG + 8'd13, 8'h10);
    settle(100);
    period_is(2 * int'(E1_HALF));
    pres[0] <= 1'b1;
    data_run();
    wr_reg(A_GCTRL, 8'h04);
    data_run();
    wr_reg(A_CHCFG, 8'h40);
    pk_lo <= 1'b1;
    lrun = 1'b1;
    settle(120);
    chk(eq_gain[0], 2);
    chk(eq_gain[5], 0);
    wr_reg(A_CHCFG, 8'h20);
    settle(4);
    chk(eq_gain[0], 1);
    pk_lo <= 1'b0;
    pk_hi <= 1'b1;
    settle(120);
    chk(eq_gain[0], 0);
    lrun = 1'b0;
    tally_and_finish();
  end
endmodule : rx_line_config_status_bench
